// ===== array_engine_model.sv
`timescale 1ns/1ps
module array_engine_model (
  // Clock and request.
  input wire logic i_core_clk,
  input wire logic i_start,
  input wire logic [3:0] i_delay,
  // Completion pulse.
  output logic o_done
);
  initial o_done = 1'b0;
  // A varying delay shows both a prompt and a slow array.
  always begin
    @(posedge i_core_clk iff i_start);
    repeat (i_delay) @(posedge i_core_clk);
    #2 o_done = 1'b1;
    @(posedge i_core_clk);
    #2 o_done = 1'b0;
  end
endmodule

// ===== sector_protect_decode.sv
`timescale 1ns/1ps
module sector_protect_decode
  import status_block_protection_pkg::*;
#(
  parameter int SECT_W = SECTOR_W
) (
  // Protection setting.
  input wire logic [BP_W-1:0] i_code,
  input wire logic i_bottom,
  // Sector under test.
  input wire logic [SECT_W-1:0] i_sector,
  output logic o_protected
);

  ////////////////////////////////////////////////////////////////////////////

  // Code n from 1 to 10 protects 2^(n-1) sectors from one end of the array; 11 and up protect all.
  function automatic logic in_range(input logic [BP_W-1:0] code,
                                    input logic bottom,
                                    input logic [SECT_W-1:0] sector);
    logic [SECT_W:0] span;
    logic [SECT_W:0] total;
    logic [SECT_W:0] idx;
    span = '0;
    total = '0;
    idx = '0;
    if (code == BP_NONE) begin
      in_range = 1'b0;
    end else if (code >= BP_ALL_MIN) begin
      in_range = 1'b1;
    end else begin
      span = (SECT_W+1)'(1) << (code - 4'h1);
      total = (SECT_W+1)'(1) << SECT_W;
      idx = {1'b0, sector};
      if (bottom) begin
        in_range = idx < span;
      end else begin
        in_range = idx >= (total - span);
      end
    end
  endfunction

  assign o_protected = in_range(i_code, i_bottom, i_sector);

endmodule

// ===== status_block_protection.sv
// Functional notes
// - 1024 sectors of 64KB, top at 03FFFFFFh.
// - Read and write status register by command.
// - Lock bit plus low pin refuses status write.
// - Only a high protect pin or a reset ends lock.
// - Bit 7 lock control, zero by default.
// - Bit 5 selects top or bottom start.
// - Protect code in bits 6,4:2 blocks writes.
// - Write-enable latch volatile, clear at power-up.
// - Program, erase, status write need latch set.
// - Bit 0 shows busy during write cycles.
// - Bit 0 is inverse of flag ready.
// - Die erase only with zero protect code.
// - Code n protects 2^(n-1) sectors.
// - Low protect pin keeps selected sectors protected.
// - Protected target: no change, set protection flag.
`timescale 1ns/1ps
module status_block_protection
  import status_block_protection_pkg::*;
#(
  parameter int SECT_W = SECTOR_W,
  parameter int A_W = ADDR_W
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Write-protect pin, low protects.
  input wire logic i_write_protect_n,
  // Decoded commands from the serial front end.
  input wire logic i_cmd_valid,
  input wire status_block_protection_pkg::cmd_t i_cmd,
  input wire logic [A_W-1:0] i_cmd_addr,
  input wire logic [SR_W-1:0] i_cmd_data,
  // Array engine completion.
  input wire logic i_op_done,
  // Register contents.
  output logic [SR_W-1:0] o_status,
  output logic o_flag_ready,
  output logic o_flag_prot_err,
  output logic o_status_locked,
  // Read answers.
  output logic o_rd_valid,
  output logic [SR_W-1:0] o_rd_data,
  // Array engine requests.
  output logic o_op_start,
  output status_block_protection_pkg::op_t o_op_kind,
  output logic [A_W-1:0] o_op_addr,
  output logic o_cmd_refused
);
  import status_block_protection_pkg::*;

  if (SECT_W < 9 || A_W != SECT_W + SECTOR_LSB) begin : g_check
    $error("Geometry cannot hold the protection table.");
  end

  typedef enum logic [1:0] {
    st_idle,
    st_busy
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  logic rst_meta;
  logic rst_n;
  logic wp_meta;
  logic wp_sync;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // The pin rises to "unprotected", so the safe reset value is low.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
    end else begin
      wp_meta <= i_write_protect_n;
      wp_sync <= wp_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  state_t state;
  state_t next_state;
  logic lock_bit;
  logic bottom;
  logic [BP_W-1:0] bp_code;
  logic wel;
  logic prot_err;
  logic [SR_W-1:0] pend_data;
  op_t pend_kind;
  logic sector_prot;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.

  wire logic busy = (state == st_busy);
  wire logic hw_locked = lock_bit & ~wp_sync;
  wire logic [SECT_W-1:0] cmd_sector =
    i_cmd_addr[SECTOR_LSB +: SECT_W];
  wire logic is_wren = i_cmd_valid && i_cmd == cmd_write_enable;
  wire logic is_wrdi = i_cmd_valid && i_cmd == cmd_write_disable;
  wire logic is_rdsr = i_cmd_valid && i_cmd == cmd_read_status;
  wire logic is_rdfs = i_cmd_valid && i_cmd == cmd_read_flags;
  wire logic is_clfs = i_cmd_valid && i_cmd == cmd_clear_flags;
  wire logic is_wrsr = i_cmd_valid && i_cmd == cmd_write_status;
  wire logic is_prog = i_cmd_valid && i_cmd == cmd_program;
  wire logic is_erase = i_cmd_valid && i_cmd == cmd_erase;
  wire logic is_die = i_cmd_valid && i_cmd == cmd_die_erase;
  wire logic is_write_op = is_wrsr | is_prog | is_erase | is_die;

  // Program and erase are refused against a protected target. The
  // pin does not relax software protection; it only adds the lock.
  wire logic prot_hit = (is_prog | is_erase) & sector_prot;
  wire logic die_blocked = is_die & (bp_code != BP_NONE);
  wire logic wrsr_blocked = is_wrsr & hw_locked;

  // Every write type needs idle and a set latch, else it is refused.
  wire logic write_ok = is_write_op & ~busy & wel;
  wire logic accept = write_ok & ~prot_hit & ~die_blocked & ~wrsr_blocked;
  wire logic refuse_latched = write_ok & ~accept;
  wire logic refuse = (is_write_op & ~accept) | (busy & is_wren);
  wire logic done = busy & i_op_done;

  // Reads return the live byte, which includes the busy bit.
  wire logic [SR_W-1:0] status_byte = pack_status(lock_bit, bottom,
                                                   bp_code, wel, busy);
  wire logic [SR_W-1:0] flag_byte = pack_flags(~busy, prot_err);

  wire op_t accept_kind = is_wrsr ? op_write_status :
                          is_prog ? op_program :
                          is_erase ? op_erase : op_die_erase;

  ////////////////////////////////////////////////////////////////////////////
  // Byte packing; the status byte is shared by the read path and the status output, the flag byte is built for reads only.

  function automatic logic [SR_W-1:0] pack_status(
      input logic lock, input logic bot, input logic [BP_W-1:0] bp,
      input logic latch, input logic bsy);
    logic [SR_W-1:0] b;
    b = BYTE_ZERO;
    b[SR_LOCK] = lock;
    b[SR_BP_HI] = bp[BP_W-1];
    b[SR_BOTTOM] = bot;
    b[SR_BP_LO_MSB:SR_BP_LO_LSB] = bp[BP_W-2:0];
    b[SR_WEL] = latch;
    b[SR_BUSY] = bsy;
    pack_status = b;
  endfunction

  function automatic logic [SR_W-1:0] pack_flags(input logic rdy,
                                                 input logic perr);
    logic [SR_W-1:0] b;
    b = BYTE_ZERO;
    b[FSR_READY] = rdy;
    b[FSR_PROT_ERR] = perr;
    pack_flags = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sector protection lookup.

  sector_protect_decode #(
    .SECT_W(SECT_W)
  ) u_decode (
    .i_code(bp_code),
    .i_bottom(bottom),
    .i_sector(cmd_sector),
    .o_protected(sector_prot)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (accept) begin
          next_state = st_busy;
        end
      end
      st_busy: begin
        if (i_op_done) begin
          next_state = st_idle;
        end
      end
    endcase
  end

  wire logic next_wel =
    (done | refuse_latched | is_wrdi) ? 1'b0 :
    (is_wren & ~busy) ? 1'b1 : wel;

  // A new error wins over a clear landing in the same cycle.
  wire logic next_prot_err =
    (prot_hit & write_ok) | (die_blocked & write_ok) ? 1'b1 :
    is_clfs ? 1'b0 : prot_err;

  ////////////////////////////////////////////////////////////////////////////
  // State and status bits.

  // Reset stands in for power-up: the nonvolatile bits come back at
  // their defaults since no array copy of them exists in this block.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      wel <= WEL_RESET;
      prot_err <= 1'b0;
    end else begin
      state <= next_state;
      wel <= next_wel;
      prot_err <= next_prot_err;
    end
  end

  // The new byte is committed when the cycle finishes, so a read
  // during the cycle still shows the old protection.
  wire logic commit = done && pend_kind == op_write_status;
  wire logic next_lock = commit ? pend_data[SR_LOCK] : lock_bit;
  wire logic next_bottom = commit ? pend_data[SR_BOTTOM] : bottom;
  // The output byte is built from these next values, so the new
  // protection shows in the same cycle as the busy bit falls.
  wire logic [BP_W-1:0] next_bp = commit ?
    {pend_data[SR_BP_HI], pend_data[SR_BP_LO_MSB:SR_BP_LO_LSB]} :
    bp_code;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_bit <= LOCK_RESET;
      bottom <= BOTTOM_RESET;
      bp_code <= BP_RESET;
    end else begin
      lock_bit <= next_lock;
      bottom <= next_bottom;
      bp_code <= next_bp;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_data <= BYTE_ZERO;
      pend_kind <= op_write_status;
    end else if (accept) begin
      pend_data <= i_cmd_data;
      pend_kind <= accept_kind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_status <= BYTE_ZERO;
      o_flag_ready <= 1'b1;
      o_flag_prot_err <= 1'b0;
      o_status_locked <= 1'b0;
    end else begin
      o_status <= pack_status(next_lock, next_bottom, next_bp, next_wel,
                              next_state == st_busy);
      o_flag_ready <= next_state != st_busy;
      o_flag_prot_err <= next_prot_err;
      o_status_locked <= hw_locked;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= BYTE_ZERO;
    end else begin
      o_rd_valid <= is_rdsr | is_rdfs;
      o_rd_data <= is_rdsr ? status_byte :
                   is_rdfs ? flag_byte : BYTE_ZERO;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_op_start <= 1'b0;
      o_op_kind <= op_write_status;
      o_op_addr <= '0;
      o_cmd_refused <= 1'b0;
    end else begin
      o_op_start <= accept;
      o_op_kind <= accept ? accept_kind : o_op_kind;
      o_op_addr <= accept ? i_cmd_addr : o_op_addr;
      o_cmd_refused <= refuse;
    end
  end

endmodule

// ===== status_block_protection_asserts.sv
`timescale 1ns/1ps
module status_block_protection_asserts
  import status_block_protection_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Command side.
  input wire logic i_cmd_valid,
  input wire status_block_protection_pkg::cmd_t i_cmd,
  input wire logic i_op_done,
  // Answers.
  input wire logic [SR_W-1:0] o_status,
  input wire logic o_flag_ready,
  input wire logic o_flag_prot_err,
  input wire logic o_status_locked,
  input wire logic o_rd_valid,
  input wire logic [SR_W-1:0] o_rd_data,
  input wire logic o_op_start,
  input wire logic o_cmd_refused
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire wr = i_cmd_valid && i_cmd == cmd_write_status;
  wire bp_set =
    {o_status[SR_BP_HI], o_status[SR_BP_LO_MSB:SR_BP_LO_LSB]} != BP_NONE;
  wire wtype = i_cmd_valid &&
    i_cmd inside {cmd_write_status, cmd_program, cmd_erase};
  a_ready_inverse: assert property (o_flag_ready == !o_status[SR_BUSY])
    else $error("ready flag not inverse of busy");
  a_start_busy: assert property (o_op_start |-> o_status[SR_BUSY])
    else $error("operation started without busy");
  a_latch_needed: assert property (wtype && !o_status[SR_WEL]
    |=> o_cmd_refused && !o_op_start) else $error("write ran without latch");
  a_lock_refuse: assert property (wr && o_status_locked |=> o_cmd_refused)
    else $error("status write ran while locked");
  a_die_guard: assert property (i_cmd_valid && i_cmd == cmd_die_erase
    && bp_set && o_status[SR_WEL] && !o_status[SR_BUSY]
    |=> o_cmd_refused && o_flag_prot_err) else $error("die erase not refused");
  a_busy_ignore: assert property (wr && o_status[SR_BUSY] && !i_op_done
    |=> o_cmd_refused ##0 $stable(o_status[7:2]))
    else $error("status write taken while busy");
  a_cycle_end: assert property (o_status[SR_BUSY] && i_op_done &&
    !i_cmd_valid |=> !o_status[SR_BUSY] && !o_status[SR_WEL])
    else $error("busy or latch left after completion");
  a_read_answer: assert property (i_cmd_valid && i_cmd == cmd_read_status
    |=> o_rd_valid && o_rd_data == $past(o_status))
    else $error("status read answer wrong");
endmodule

bind status_block_protection status_block_protection_asserts u_chk (
  .i_core_clk, .i_rst_n, .i_cmd_valid, .i_cmd, .i_op_done, .o_status,
  .o_flag_ready, .o_flag_prot_err, .o_status_locked, .o_rd_valid,
  .o_rd_data, .o_op_start, .o_cmd_refused
);

// ===== status_block_protection_pkg.sv
package status_block_protection_pkg;

  // Array geometry.
  localparam int ADDR_W = 26;
  localparam int SECTOR_W = 10;
  localparam int SECTOR_LSB = 16;
  localparam int BP_W = 4;
  localparam logic [BP_W-1:0] BP_NONE = 4'h0;
  localparam logic [BP_W-1:0] BP_ALL_MIN = 4'hb;

  // Status register layout.
  localparam int SR_W = 8;
  localparam int SR_LOCK = 7;
  localparam int SR_BP_HI = 6;
  localparam int SR_BOTTOM = 5;
  localparam int SR_BP_LO_MSB = 4;
  localparam int SR_BP_LO_LSB = 2;
  localparam int SR_WEL = 1;
  localparam int SR_BUSY = 0;

  // Flag status register layout.
  localparam int FSR_READY = 7;
  localparam int FSR_PROT_ERR = 1;

  // Power-up values of the status fields.
  localparam logic LOCK_RESET = 1'b0;
  localparam logic BOTTOM_RESET = 1'b0;
  localparam logic [BP_W-1:0] BP_RESET = 4'h0;
  localparam logic WEL_RESET = 1'b0;
  localparam logic [SR_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [3:0] {
    cmd_write_enable,
    cmd_write_disable,
    cmd_read_status,
    cmd_write_status,
    cmd_read_flags,
    cmd_clear_flags,
    cmd_program,
    cmd_erase,
    cmd_die_erase
  } cmd_t;

  typedef enum logic [1:0] {
    op_write_status,
    op_program,
    op_erase,
    op_die_erase
  } op_t;

endpackage

// ===== status_block_protection_tb.sv
`timescale 1ns/1ps
module status_block_protection_tb;
  import status_block_protection_pkg::*;
  logic clk, rst_n, wp_n, valid, done, fr, pe, lk, rv, os, rf;
  cmd_t cmd;
  op_t ok;
  logic [25:0] addr, oa, a;
  logic [7:0] data, st, rd;
  logic [3:0] dly;
  integer seed = 32'hdeacabd0;
  int fails = 0;
  int checks_done = 0;
  int s, lim;
  logic e;

  status_block_protection DUT (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_write_protect_n(wp_n), .i_cmd_valid(valid), .i_cmd(cmd),
    .i_cmd_addr(addr), .i_cmd_data(data), .i_op_done(done), .o_status(st),
    .o_flag_ready(fr), .o_flag_prot_err(pe), .o_status_locked(lk),
    .o_rd_valid(rv), .o_rd_data(rd), .o_op_start(os), .o_op_kind(ok),
    .o_op_addr(oa), .o_cmd_refused(rf));
  array_engine_model u_eng (.i_core_clk(clk), .i_start(os), .i_delay(dly),
    .o_done(done));

  task automatic stop_test;
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] v, x);
    checks_done++;
    if (v !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, v);
    end
  endtask

  // Answers are sampled 2 ns after the taking edge, while they stand.
  task automatic issue(input cmd_t c, input logic [25:0] ad, logic [7:0] d);
    @(posedge clk);
    #2;
    valid = 1;
    cmd = c;
    addr = ad;
    data = d;
    @(posedge clk);
    #2 valid = 0;
  endtask

  task automatic idle;
    for (int n = 0; st[SR_BUSY] !== 1'b0; n++) begin
      @(posedge clk);
      #2;
      if (n > 40) begin
        fails++;
        stop_test;
      end
    end
  endtask

  task automatic wrsr(input logic [7:0] d);
    issue(cmd_write_enable, 0, 0);
    issue(cmd_write_status, 0, d);
    check("wrsr start", {os, st[SR_BUSY], fr}, 3'b110);
    idle;
    check("status", st, {d[7:2], 2'b00});
  endtask

  function automatic int edge_of(input logic [3:0] c, input logic b);
    int n;
    n = (c == 0) ? 0 : (c > 10) ? 1024 : 1 << (c - 1);
    return b ? n : 1024 - n;
  endfunction

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst_n = 0;
    wp_n = 1;
    valid = 0;
    cmd = cmd_read_status;
    addr = 0;
    data = 0;
    dly = 0;
    repeat (5) @(posedge clk);
    #2 rst_n = 1;
    repeat (6) @(posedge clk);
    #2;
    check("reset", {st, fr, pe}, 10'h002);
    issue(cmd_program, 26'h3ff0000, 0);
    check("no latch", {rf, os}, 2'b10);
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 16; c++) begin
        wrsr({1'b0, c[3], b[0], c[2:0], 2'($random(seed))});
        lim = edge_of(c, b);
        for (int k = 0; k < 3; k++) begin
          s = (k == 2) ? $random(seed) : lim - k;
          a = {s[9:0], 16'($random(seed))};
          e = b ? (s[9:0] < lim) : (s[9:0] >= lim);
          dly = 4'($random(seed));
          issue(cmd_clear_flags, 0, 0);
          issue(cmd_write_enable, 0, 0);
          issue(k[0] ? cmd_erase : cmd_program, a, 0);
          check("refused", {rf, os, pe}, {e, !e, e});
          if (e) check("latch", st[SR_WEL], 0);
          else check("target", {ok, oa},
                     {k[0] ? op_erase : op_program, a});
          idle;
        end
        issue(cmd_write_enable, 0, 0);
        issue(cmd_die_erase, 0, 0);
        check("die", rf, c != 0);
        idle;
      end
    end
    wrsr(8'h80);
    wp_n = 0;
    repeat (4) @(posedge clk);
    #2 check("locked", lk, 1);
    issue(cmd_write_enable, 0, 0);
    issue(cmd_write_status, 0, 8'h00);
    check("lock refuse", {rf, st}, 9'h180);
    wp_n = 1;
    repeat (4) @(posedge clk);
    wrsr(8'h00);
    dly = 15;
    issue(cmd_write_enable, 0, 0);
    issue(cmd_program, 26'h1230000, 0);
    issue(cmd_write_status, 0, 8'hfc);
    check("busy refuse", {rf, st[7:2]}, 7'h40);
    issue(cmd_read_status, 0, 0);
    check("busy read", {rv, rd[0], fr}, 3'b110);
    idle;
    issue(cmd_write_enable, 0, 0);
    issue(cmd_write_disable, 0, 0);
    check("wel off", st[SR_WEL], 0);
    issue(cmd_program, 0, 0);
    check("no latch 2", {rf, os}, 2'b10);
    // The last blocked die erase left the error flag standing.
    issue(cmd_read_flags, 0, 0);
    check("flags", {rv, rd}, 9'h182);
    issue(cmd_clear_flags, 0, 0);
    issue(cmd_read_flags, 0, 0);
    check("flags clear", {rv, rd}, 9'h180);
    // A second power-up must drop a latch that was set before it.
    issue(cmd_write_enable, 0, 0);
    rst_n = 0;
    repeat (2) @(posedge clk);
    #2 rst_n = 1;
    repeat (6) @(posedge clk);
    #2 check("power-up", {st, fr, pe}, 10'h002);
    stop_test;
  end
endmodule
